// ==== hw/ats_pkg.sv ====
/*
  ats_pkg: register map, fields, source codes, states and timebase.
  Assumes a 25 MHz sys_clk and a 32-bit Avalon-MM register port.
*/
package ats_pkg;

  localparam int NCH         = 2;
  localparam int NSEQ        = 4;
  localparam int NDIO        = 14;
  localparam int NLINE       = 2;
  localparam int NTP         = 6;
  localparam int SEQ_REGS    = 8;
  localparam int CFG_IDX_W   = 5;
  localparam int KIND_SRC    = 0;
  localparam int KIND_MEAS   = 1;

  // delays, periods and waits count in microsecond ticks
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;

  // global register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_BUS_TRG  = 8'h04;
  localparam logic [7:0] REG_MODE     = 8'h08;
  localparam logic [7:0] REG_STATUS   = 8'h0c;
  localparam logic [7:0] REG_WAIT0    = 8'h10;
  localparam logic [7:0] REG_WAIT1    = 8'h14;
  localparam logic [7:0] SEQ_BASE     = 8'h80;
  localparam logic [7:0] SEQ_MASK     = 8'h80;

  // word index inside a sequencer block
  localparam int SR_SRC      = 0;
  localparam int SR_ARM_CNT  = 1;
  localparam int SR_TRG_CNT  = 2;
  localparam int SR_ARM_DLY  = 3;
  localparam int SR_TRG_DLY  = 4;
  localparam int SR_ACT_DLY  = 5;
  localparam int SR_PERIOD   = 6;

  localparam logic [31:0] CNT_RST = 32'h0000_0001;

  // field positions
  localparam int CTRL_INIT_LSB  = 0;
  localparam int CTRL_ABORT_LSB = 4;
  localparam int MODE_GROUP_BIT = 0;
  localparam int MODE_AUTO_BIT  = 1;
  localparam int SRC_ARM_LSB    = 0;
  localparam int SRC_TRG_LSB    = 8;
  localparam int SRC_TOUT_LSB   = 16;
  localparam int STAT_GOK_BIT   = 4;
  localparam int STAT_ST_LSB    = 8;

  // event source codes
  localparam int SEL_W = 5;
  localparam int NSRC  = 20;
  localparam logic [SEL_W-1:0] SEL_AUTO      = 5'h00;
  localparam logic [SEL_W-1:0] SEL_BUS       = 5'h01;
  localparam logic [SEL_W-1:0] SEL_TIMER     = 5'h02;
  localparam logic [SEL_W-1:0] SEL_LINE_ONE  = 5'h03;
  localparam logic [SEL_W-1:0] SEL_LINE_TWO  = 5'h04;
  localparam logic [SEL_W-1:0] SEL_DIO_FIRST = 5'h05;
  localparam logic [SEL_W-1:0] SEL_DIO_LAST  = 5'h12;
  localparam logic [SEL_W-1:0] SEL_LAN       = 5'h13;

  // trigger output timing points
  localparam int TP_ARM_START = 0;
  localparam int TP_ARM_END   = 1;
  localparam int TP_TRG_START = 2;
  localparam int TP_TRG_END   = 3;
  localparam int TP_ACT_START = 4;
  localparam int TP_ACT_END   = 5;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_ARM_WAIT = 3'h1,
    ST_ARM_DLY  = 3'h2,
    ST_TRG_WAIT = 3'h3,
    ST_TRG_DLY  = 3'h4,
    ST_ACT_DLY  = 3'h5,
    ST_ACT_GATE = 3'h6,
    ST_ACT_BUSY = 3'h7
  } ats_state_t;

endpackage

// ==== hw/ats_sequencer.sv ====
/*
  ats_sequencer: source and measure arm/trigger sequencers of two channels
  behind an Avalon-MM slave.
  Assumes done and output-on inputs on sys_clk; trigger pins are asynchronous.
*/
// Added by the designer: register access over Avalon-MM and the placing of the registers.
//
// Contract
// R1: initiation moves an idle sequencer into the arm layer first
// R2: arm layer waits for an event from the arm source
// R3: after arm event, arm delay runs out before trigger layer
// R4: trigger layer waits for an event from the trigger source
// R5: after trigger event, trigger delay runs out, then action launches
// R6: trigger loop repeats to its count, then back to arm layer
// R7: arm loop repeats to its count, then back to idle
// R8: separate source and measure sequencers, started together or apart
// R9: each sequencer has its own arm and trigger source selection
// R10: sources: auto, bus command, timer, two bus lines, dio 1-14, network
// R11: timer source pulses once per programmed period; code pulses once every period + 1 ticks
// R12: remote controller raises bus events with a trigger command
// R13: source action applies one value after its own delay
// R14: measure action takes one reading after its own delay
// R15: auto mode with output on suppresses source actions
// R16: grouped: sources in channel order, measures together, output held
// R17: ungrouped channels run independently
// R18: grouping valid only with equal sources, and equal timer periods; code checks trigger sources only, source periods unless trigger count is 1
// R19: running wait time blocks measurement and source change
// R20: grouped wait starts at last source change of last channel
// R21: equal sources and delays with wait off start actions together
// R22: trigger out selectable at start/end of arm, trigger, action
// R23: delays, periods, waits count down on a microsecond timebase
// R24: edge events are one-cycle pulses, ignored unless awaited
`timescale 1ns/100ps
module ats_sequencer
  import ats_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic [5:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic [NLINE-1:0]  internal_bus_line_in,
  input  wire logic [NDIO-1:0]   dio_line_in,
  input  wire logic              lan_trig_in,
  input  wire logic [NCH-1:0]    chan_output_on,
  output logic      [NCH-1:0]    source_output_action,
  input  wire logic [NCH-1:0]    source_output_done,
  output logic      [NCH-1:0]    measurement_action,
  input  wire logic [NCH-1:0]    measurement_done,
  output logic      [NSEQ-1:0]   trig_out,
  output logic      [NSEQ-1:0]   seq_busy
);

////////////////////////////////////////////////////////////////////////////
  localparam int NPIN  = NLINE + NDIO + 1;
  localparam int PRE_W = $clog2(TICK_CYC);

  logic              ack_r;
  logic [31:0]       rd_nxt;
  logic [31:0]       be_m;
  logic [31:0]       readdata_r;
  logic [31:0]       cfg_r [NSEQ*SEQ_REGS];
  logic [31:0]       wait_r [NCH];
  logic [1:0]        mode_r;
  logic [7:0]        baddr;
  logic              wr_go;
  logic              seq_hit;
  logic [NSEQ-1:0]   init_p;
  logic [NSEQ-1:0]   abort_p;
  logic              bus_trg_p;
  logic [PRE_W-1:0]  pre_r;
  logic              tick;
  logic [NPIN-1:0]   pin_s1_r;
  logic [NPIN-1:0]   pin_s2_r;
  logic [NPIN-1:0]   pin_s3_r;
  logic [NPIN-1:0]   pin_edge;
  ats_state_t        st_r [NSEQ];
  logic [NSEQ-1:0]   in_gate;
  logic [NSEQ-1:0]   in_busy;
  logic [NSEQ-1:0]   act_r;
  logic [NSEQ-1:0]   tout_r;
  logic [NCH-1:0]    wz;
  logic [31:0]       wait_cnt_r [NCH];
  logic [NSEQ*3-1:0] st_flat;
  logic              group_ok;
  logic              grp;
  logic              mbusy;

  function automatic logic pick(input logic [NSRC-1:0]  v,
                                input logic [SEL_W-1:0] sel);
    return (sel < SEL_W'(NSRC)) ? v[sel] : 1'b0;
  endfunction

////////////////////////////////////////////////////////////////////////////
// avalon slave: one wait cycle, then the answer stands for one cycle

  assign baddr           = {avs_address, 2'b00};
  assign seq_hit         = (baddr & SEQ_MASK) == SEQ_BASE;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign avs_readdata    = readdata_r;
  assign wr_go           = avs_write & ack_r;
  assign be_m            = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                            {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ack_r <= 1'b0;
    else
      ack_r <= (avs_read | avs_write) & ~ack_r;
  end

  always_comb
  begin
    rd_nxt = '0;
    if (seq_hit)
      rd_nxt = cfg_r[avs_address[CFG_IDX_W-1:0]];
    else if (baddr == REG_MODE)
      rd_nxt[1:0] = mode_r;
    else if (baddr == REG_STATUS)
    begin
      rd_nxt[NSEQ-1:0]                    = seq_busy;
      rd_nxt[STAT_GOK_BIT]                = group_ok;
      rd_nxt[STAT_ST_LSB +: NSEQ*3]       = st_flat;
    end
    else if (baddr == REG_WAIT0)
      rd_nxt = wait_r[0];
    else if (baddr == REG_WAIT1)
      rd_nxt = wait_r[1];
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      readdata_r <= '0;
    else if (avs_read & ~ack_r)
      readdata_r <= rd_nxt;
  end

  // control and bus-trigger words are write-only
  assign init_p  = (wr_go && baddr == REG_CTRL && avs_byteenable[0]) ?
                   avs_writedata[CTRL_INIT_LSB +: NSEQ] : '0;
  assign abort_p = (wr_go && baddr == REG_CTRL && avs_byteenable[0]) ?
                   avs_writedata[CTRL_ABORT_LSB +: NSEQ] : '0;
  assign bus_trg_p = wr_go && baddr == REG_BUS_TRG; // R12

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_r    <= '0;
      wait_r[0] <= '0;
      wait_r[1] <= '0;
    end
    else if (wr_go)
    begin
      if (baddr == REG_MODE && avs_byteenable[0])
        mode_r <= avs_writedata[1:0];
      if (baddr == REG_WAIT0)
        wait_r[0] <= (wait_r[0] & ~be_m) | (avs_writedata & be_m);
      if (baddr == REG_WAIT1)
        wait_r[1] <= (wait_r[1] & ~be_m) | (avs_writedata & be_m);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NSEQ*SEQ_REGS; i++)
        cfg_r[i] <= (i % SEQ_REGS == SR_ARM_CNT || i % SEQ_REGS == SR_TRG_CNT) ?
                    CNT_RST : '0;
    end
    else if (wr_go && seq_hit)
      cfg_r[avs_address[CFG_IDX_W-1:0]] <=
        (cfg_r[avs_address[CFG_IDX_W-1:0]] & ~be_m) | (avs_writedata & be_m);
  end

////////////////////////////////////////////////////////////////////////////
// timebase and pin event detection

  assign tick = pre_r == '0;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      pre_r <= '0;
    else if (tick)
      pre_r <= PRE_W'(TICK_CYC - 1); // R23
    else
      pre_r <= pre_r - PRE_W'(1);
  end

  // s1 feeds only s2; edges are taken between s2 and s3
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
    end
    else
    begin
      pin_s1_r <= {lan_trig_in, dio_line_in, internal_bus_line_in};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  assign pin_edge = pin_s2_r & ~pin_s3_r; // R24

////////////////////////////////////////////////////////////////////////////
// grouping and wait-time gating

  assign group_ok =
    cfg_r[SR_SRC][SRC_TRG_LSB +: SEL_W] ==
      cfg_r[2*SEQ_REGS + SR_SRC][SRC_TRG_LSB +: SEL_W] &&
    cfg_r[SEQ_REGS + SR_SRC][SRC_TRG_LSB +: SEL_W] ==
      cfg_r[3*SEQ_REGS + SR_SRC][SRC_TRG_LSB +: SEL_W] &&
    (cfg_r[SR_SRC][SRC_TRG_LSB +: SEL_W] != SEL_TIMER ||
     cfg_r[SR_TRG_CNT][CNT_W-1:0] == CNT_W'(1) ||
     cfg_r[SR_PERIOD] == cfg_r[2*SEQ_REGS + SR_PERIOD]); // R18
  assign grp   = mode_r[MODE_GROUP_BIT] & group_ok; // R17
  assign mbusy = in_busy[1] | in_busy[3];

  genvar c;
    for (c = 0; c < NCH; c++)
    begin : g_wait
      logic load;
      // grouped: both waits start from the last source change of channel 1
      assign load = grp ? (in_busy[2] & source_output_done[1]) // R20
                        : (in_busy[2*c] & source_output_done[c]);
      assign wz[c] = wait_cnt_r[c] == '0;

      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
          wait_cnt_r[c] <= '0;
        else if (load)
          wait_cnt_r[c] <= wait_r[c];
        else if (tick && !wz[c])
          wait_cnt_r[c] <= wait_cnt_r[c] - 32'h1; // R19
      end
    end

////////////////////////////////////////////////////////////////////////////
// four sequencers: index is channel*2 + kind

  genvar s;
    for (s = 0; s < NSEQ; s++)
    begin : g_seq // R8
      localparam int CH   = s / 2;
      localparam int KIND = s % 2;
      localparam int B    = s * SEQ_REGS;

      logic [31:0]      tmr_r;
      logic             tev_r;
      logic [CNT_W-1:0] arm_left_r;
      logic [CNT_W-1:0] trg_left_r;
      logic [31:0]      dly_r;
      logic [NSRC-1:0]  evv;
      logic             ev_arm;
      logic             ev_trg;
      logic             dz;
      logic             gate_ok;
      logic             suppress;
      logic             launch;
      logic             done;
      logic             fin;
      logic             last_trg;
      logic             last_arm;
      logic [NTP-1:0]   tp;

      assign evv = {pin_edge[NPIN-1], pin_edge[NLINE +: NDIO],
                    pin_edge[NLINE-1:0], tev_r, bus_trg_p, 1'b1}; // R10
      assign ev_arm = pick(evv, cfg_r[B + SR_SRC][SRC_ARM_LSB +: SEL_W]); // R9
      assign ev_trg = pick(evv, cfg_r[B + SR_SRC][SRC_TRG_LSB +: SEL_W]);
      assign dz     = dly_r == '0;
      assign in_gate[s] = st_r[s] == ST_ACT_GATE;
      assign in_busy[s] = st_r[s] == ST_ACT_BUSY;
      assign seq_busy[s] = st_r[s] != ST_IDLE;
      assign st_flat[s*3 +: 3] = st_r[s];

      if (KIND == KIND_SRC)
      begin : g_src
        assign suppress = mode_r[MODE_AUTO_BIT] & chan_output_on[CH]; // R15
        assign done     = source_output_done[CH];
        // grouped: channel 1 waits while channel 0 is at its gate or changing its output
        assign gate_ok  = wz[CH] & ~(grp & mbusy) &
                          ~(grp && CH != 0 && (in_gate[0] | in_busy[0])); // R16
        assign source_output_action[CH] = act_r[s]; // R13
      end
      else
      begin : g_meas
        assign suppress = 1'b0;
        assign done     = measurement_done[CH];
        // grouped measures leave the gate in the same cycle
        assign gate_ok  = grp ? (in_gate[1] & in_gate[3] & wz[0] & wz[1] &
                                 ~(in_busy[0] | in_busy[2] |
                                   in_gate[0] | in_gate[2]))  // R16
                              : wz[CH];                       // R21
        assign measurement_action[CH] = act_r[s]; // R14
      end

      assign launch   = in_gate[s] & gate_ok & ~suppress;
      assign fin      = (in_busy[s] & done) | (in_gate[s] & gate_ok & suppress);
      assign last_trg = trg_left_r <= CNT_W'(1);
      assign last_arm = arm_left_r <= CNT_W'(1);

      assign tp[TP_ARM_START] = st_r[s] == ST_IDLE && init_p[s];
      assign tp[TP_ARM_END]   = fin & last_trg & last_arm;
      assign tp[TP_TRG_START] = st_r[s] == ST_ARM_DLY && dz;
      assign tp[TP_TRG_END]   = fin & last_trg;
      assign tp[TP_ACT_START] = launch;
      assign tp[TP_ACT_END]   = in_busy[s] & done;

      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          tmr_r <= '0;
          tev_r <= 1'b0;
        end
        else if (st_r[s] == ST_IDLE)
        begin
          tmr_r <= cfg_r[B + SR_PERIOD];
          tev_r <= 1'b0;
        end
        else
        begin
          tev_r <= tick && tmr_r == '0; // R11
          if (tick)
            tmr_r <= (tmr_r == '0) ? cfg_r[B + SR_PERIOD] : tmr_r - 32'h1;
        end
      end

      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          act_r[s]  <= 1'b0;
          tout_r[s] <= 1'b0;
        end
        else
        begin
          act_r[s]  <= launch;
          tout_r[s] <= |(tp & cfg_r[B + SR_SRC][SRC_TOUT_LSB +: NTP]); // R22
        end
      end

      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          st_r[s]    <= ST_IDLE;
          arm_left_r <= '0;
          trg_left_r <= '0;
          dly_r      <= '0;
        end
        else if (abort_p[s])
          st_r[s] <= ST_IDLE;
        else
        begin
          unique case (st_r[s])
            ST_IDLE:
              if (init_p[s])
              begin
                st_r[s]    <= ST_ARM_WAIT; // R1
                arm_left_r <= cfg_r[B + SR_ARM_CNT][CNT_W-1:0];
              end
            ST_ARM_WAIT:
              if (ev_arm)
              begin
                st_r[s] <= ST_ARM_DLY; // R2
                dly_r   <= cfg_r[B + SR_ARM_DLY];
              end
            ST_ARM_DLY:
              if (dz)
              begin
                st_r[s]    <= ST_TRG_WAIT; // R3
                trg_left_r <= cfg_r[B + SR_TRG_CNT][CNT_W-1:0];
              end
              else if (tick)
                dly_r <= dly_r - 32'h1;
            ST_TRG_WAIT:
              if (ev_trg)
              begin
                st_r[s] <= ST_TRG_DLY; // R4
                dly_r   <= cfg_r[B + SR_TRG_DLY];
              end
            ST_TRG_DLY:
              if (dz)
              begin
                st_r[s] <= ST_ACT_DLY; // R5
                dly_r   <= cfg_r[B + SR_ACT_DLY];
              end
              else if (tick)
                dly_r <= dly_r - 32'h1;
            ST_ACT_DLY:
              if (dz)
                st_r[s] <= ST_ACT_GATE;
              else if (tick)
                dly_r <= dly_r - 32'h1;
            ST_ACT_GATE, ST_ACT_BUSY:
              if (fin)
              begin
                if (!last_trg)
                begin
                  st_r[s]    <= ST_TRG_WAIT; // R6
                  trg_left_r <= trg_left_r - CNT_W'(1);
                end
                else if (!last_arm)
                begin
                  st_r[s]    <= ST_ARM_WAIT; // R7
                  arm_left_r <= arm_left_r - CNT_W'(1);
                end
                else
                  st_r[s] <= ST_IDLE;
              end
              else if (launch)
                st_r[s] <= ST_ACT_BUSY;
          endcase
        end
      end
    end

  assign trig_out = tout_r;

endmodule

// ==== tb/ats_sva.sv ====
/*
  ats_sva: port-level checker for ats_sequencer, attached by bind.
  assumes one clock domain and the asynchronous active-low reset.
*/
`timescale 1ns/100ps
module ats_sva
  import ats_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic [5:0]        avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic [NCH-1:0]    chan_output_on,
  input wire logic [NCH-1:0]    source_output_action,
  input wire logic [NCH-1:0]    measurement_action,
  input wire logic [NCH-1:0]    measurement_done,
  input wire logic [NSEQ-1:0]   trig_out,
  input wire logic [NSEQ-1:0]   seq_busy
);
  logic       ctl_wr;
  logic [1:0] mode_r;

  assign ctl_wr = avs_write && !avs_waitrequest && avs_address == 6'h00;

  // shadow of the mode word, rebuilt from bus traffic alone
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      mode_r <= 2'h0;
    else if (avs_write && !avs_waitrequest && avs_address == 6'h02 && avs_byteenable[0])
      mode_r <= avs_writedata[1:0];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////
  wait_one_a: assert property ($rose(avs_read || avs_write)
    |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("late bus answer");
  mode_read_a: assert property (avs_read && !avs_waitrequest && avs_address == 6'h02
    |-> avs_readdata[1:0] == mode_r)
    else $error("bad mode readback");
  init_first_a: assert property ($rose(seq_busy[1]) |-> $past(ctl_wr) || $past(ctl_wr, 2))
    else $error("start without initiation");
  src_pulse_a: assert property (source_output_action[0] |=> !source_output_action[0])
    else $error("long source action");
  meas_pulse_a: assert property (measurement_action[1] |=> !measurement_action[1])
    else $error("long measure action");
  act_busy_a: assert property (measurement_action[0] |-> seq_busy[1])
    else $error("measure while idle");
  src_busy_a: assert property (source_output_action[1] |-> seq_busy[2])
    else $error("source while idle");
  meas_end_a: assert property ($fell(seq_busy[1])
    |-> $past(measurement_done[0] || ctl_wr) || $past(ctl_wr, 2))
    else $error("idle without completion");
  auto_quiet_a: assert property (mode_r[1] && chan_output_on[0]
    && $past(mode_r[1] && chan_output_on[0]) |-> !source_output_action[0])
    else $error("source action in auto mode");
  tout_busy_a: assert property (trig_out[1] |-> seq_busy[1] || $past(seq_busy[1]))
    else $error("trigger out while idle");

  cover property (source_output_action[0]);
  cover property (measurement_action[0] && measurement_action[1]);
  cover property (trig_out[1]);
  cover property ($fell(seq_busy[1]));
endmodule

bind ats_sequencer ats_sva chk (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .chan_output_on,
  .source_output_action, .measurement_action, .measurement_done, .trig_out, .seq_busy);

// ==== tb/ats_far_model.sv ====
/*
  ats_far_model: answers each action pulse with a done pulse after lat cycles.
  assumes lat is at least 1 and changes only between actions.
*/
`timescale 1ns/100ps
module ats_far_model
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [3:0]  lat,
  input wire logic [1:0]  source_output_action,
  input wire logic [1:0]  measurement_action,
  output logic     [1:0]  source_output_done,
  output logic     [1:0]  measurement_done
);
  logic [3:0] act;
  logic [3:0] done_r;
  logic [3:0] cnt_r [4];

  assign act = {measurement_action, source_output_action};
  assign {measurement_done, source_output_done} = done_r;

  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      done_r <= 4'h0;
      cnt_r <= '{default: 4'h0};
    end
    else
      for (int i = 0; i < 4; i++)
      begin
        done_r[i] <= !act[i] && cnt_r[i] == 4'h1;
        cnt_r[i] <= act[i] ? lat : (cnt_r[i] != 4'h0 ? cnt_r[i] - 4'h1 : 4'h0);
      end
endmodule

// ==== tb/tb_top.sv ====
/*
  tb_top: random and directed runs of ats_sequencer with the far model.
  assumes 25 MHz sys_clk and one-cycle action pulses.
*/
`timescale 1ns/100ps
module tb_top
  import ats_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  line_in = 2'h0;
  logic [13:0] dio_in = 14'h0;
  logic        lan_in = 1'b0;
  logic [1:0]  out_on = 2'h0;
  logic [3:0]  lat = 4'h2;
  logic [1:0]  sa, sd, ma, md;
  logic [3:0]  tout, busy;
  int          fails = 0;
  int          comparisons = 0;
  int          cyc = 0, sd_t = 0, to_n = 0;
  int          sa_n [2], ma_n [2], sa_t [2], ma_t [2];

  ats_sequencer uut (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
    .internal_bus_line_in(line_in), .dio_line_in(dio_in), .lan_trig_in(lan_in),
    .chan_output_on(out_on), .source_output_action(sa), .source_output_done(sd),
    .measurement_action(ma), .measurement_done(md), .trig_out(tout), .seq_busy(busy));
  ats_far_model far (.sys_clk, .rst_n, .lat, .source_output_action(sa),
    .source_output_done(sd), .measurement_action(ma), .measurement_done(md));

  initial forever #20 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    to_n <= to_n + (tout[1] === 1'b1);
    sd_t <= (sd[0] === 1'b1) ? cyc : sd_t;
    for (int i = 0; i < 2; i++)
    begin
      sa_n[i] <= sa_n[i] + (sa[i] === 1'b1);
      ma_n[i] <= ma_n[i] + (ma[i] === 1'b1);
      sa_t[i] <= (sa[i] === 1'b1) ? cyc : sa_t[i];
      ma_t[i] <= (ma[i] === 1'b1) ? cyc : ma_t[i];
    end
  end

  ////////////////////////////////////////
  task automatic final_report();
    if (fails == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int v, input int lo, input int hi);
    comparisons++;
    if (v < lo || v > hi)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
    end
  endtask

  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask

  function automatic logic [31:0] srcw(input logic [4:0] a, t, input logic [5:0] m);
    return {10'h0, m, 3'h0, t, 3'h0, a};
  endfunction

  task automatic cfg(input int s, input logic [31:0] src, input int ac, tc, ad, td, xd);
    logic [5:0] b;
    b = 6'h20 + 6'(s * 8);
    wr(b, src);
    wr(b + 6'h1, ac);
    wr(b + 6'h2, tc);
    wr(b + 6'h3, ad);
    wr(b + 6'h4, td);
    wr(b + 6'h5, xd);
    wr(b + 6'h6, 32'h3);
  endtask

  task automatic idle();
    do @(negedge sys_clk); while (busy !== 4'h0);
  endtask

  task automatic wait_ma(input int n);
    while (ma_n[0] < n) @(negedge sys_clk);
  endtask

  // held four cycles so the synchroniser sees the edge
  task automatic fire(input int c);
    if (c == 1)
      wr(REG_BUS_TRG[7:2], 32'h0);
    else if (c >= 3)
    begin
      @(posedge sys_clk);
      {lan_in, dio_in, line_in} <= 17'h1 << (c - 3);
      repeat (4) @(posedge sys_clk);
      {lan_in, dio_in, line_in} <= 17'h0;
    end
  endtask

  initial
  begin
    repeat (60000) @(posedge sys_clk);
    fails++;
    final_report();
  end

  ////////////////////////////////////////
  initial
  begin
    int a, t, d, m, n0, t0, e;
    logic [31:0] q;
    void'($urandom(28454));
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(REG_MODE[7:2], q);
    chk32(q, 32'h0);
    rd(6'h21, q);
    chk32(q, CNT_RST);
    rd(6'h2a, q);
    chk32(q, CNT_RST);
    wr(6'h06, 32'hffff_ffff);
    rd(6'h06, q);
    chk32(q, 32'h0);
    for (int c = 0; c < NSRC; c++)
    begin
      if (c % 2 == 1)
        cfg(1, srcw(5'(c), SEL_AUTO, 6'h0), 1, 1, 0, 0, 0);
      else
        cfg(1, srcw(SEL_AUTO, 5'(c), 6'h0), 1, 1, 0, 0, 0);
      n0 = ma_n[0];
      wr(REG_CTRL[7:2], 32'h2);
      repeat (30) @(posedge sys_clk);
      if (c != 0 && c != 2)
        chk32(ma_n[0] - n0, 0);
      fire(c);
      wait_ma(n0 + 1);
      chk32(ma_n[0] - n0, 1);
      idle();
    end
    for (int i = 0; i < 3; i++)
    begin
      a = (i == 0) ? 0 : 1 + $urandom % 3;
      t = 1 + $urandom % 3;
      lat <= 4'(1 + $urandom % 6);
      cfg(1, srcw(SEL_AUTO, SEL_AUTO, 6'h0), a, t, 0, 0, 0);
      n0 = ma_n[0];
      wr(REG_CTRL[7:2], 32'h2);
      idle();
      chk32(ma_n[0] - n0, (a == 0 ? 1 : a) * t);
    end
    a = 2 + $urandom % 4;
    t = 2 + $urandom % 4;
    d = 2 + $urandom % 4;
    cfg(1, srcw(SEL_AUTO, SEL_AUTO, 6'h1 << ($urandom % 6)), 1, 1, a, t, d);
    n0 = ma_n[0];
    e = to_n;
    wr(REG_CTRL[7:2], 32'h2);
    t0 = cyc;
    wait_ma(n0 + 1);
    chk_rng(ma_t[0] - t0, (a + t + d - 3) * TICK_CYC, (a + t + d + 1) * TICK_CYC + 10);
    idle();
    chk32(to_n - e, 1);
    wr(REG_MODE[7:2], 32'h2);
    out_on <= 2'b01;
    for (int s = 0; s < 3; s++)
      cfg(s, srcw(SEL_AUTO, SEL_AUTO, 6'h0), 1, 2, 0, 0, 0);
    n0 = sa_n[0];
    t0 = ma_n[0];
    e = sa_n[1];
    wr(REG_CTRL[7:2], 32'h7);
    idle();
    chk32(sa_n[0] - n0, 0);
    chk32(ma_n[0] - t0, 2);
    chk32(sa_n[1] - e, 2);
    wr(REG_MODE[7:2], 32'h0);
    out_on <= 2'b00;
    m = 3 + $urandom % 4;
    lat <= 4'h2;
    wr(REG_WAIT0[7:2], 32'(m));
    cfg(0, srcw(SEL_AUTO, SEL_AUTO, 6'h0), 1, 1, 0, 0, 0);
    cfg(1, srcw(SEL_AUTO, SEL_AUTO, 6'h0), 1, 1, 0, 0, 2);
    wr(REG_CTRL[7:2], 32'h3);
    idle();
    chk_rng(ma_t[0] - sd_t, (m - 1) * TICK_CYC, (m + 1) * TICK_CYC + 10);
    wr(REG_WAIT0[7:2], 32'h0);
    wr(REG_MODE[7:2], 32'h1);
    for (int s = 0; s < 4; s++)
      cfg(s, srcw(SEL_AUTO, SEL_AUTO, 6'h0), 1, 1, 0, 0, 0);
    rd(REG_STATUS[7:2], q);
    chk32(q[STAT_GOK_BIT], 1);
    wr(REG_CTRL[7:2], 32'hf);
    idle();
    chk32(sa_t[0] < sa_t[1], 1);
    chk32(ma_t[0] > sa_t[1], 1);
    chk32(ma_t[0], ma_t[1]);
    cfg(3, srcw(SEL_AUTO, SEL_BUS, 6'h0), 1, 1, 0, 0, 0);
    rd(REG_STATUS[7:2], q);
    chk32(q[STAT_GOK_BIT], 0);
    wr(REG_MODE[7:2], 32'h0);
    final_report();
  end
endmodule
